// ### logic/dax_params.svh
// Constants for the extended ALU and MAC datapath block
`ifndef DAX_PARAMS_SVH
`define DAX_PARAMS_SVH
`define DAX_W          16
`define DAX_MR_W       40
`define DAX_RND_HALF   16'h8000
`define DAX_BIAS_BIT   12
`define DAX_ZERO       16'h0000
`define DAX_ONE        16'h0001
`define DAX_MINUS_ONE  16'hFFFF
`define DAX_SRC_N      8
`define DAX_LOW_HI     15
`define DAX_MID_LO     16
`define DAX_MID_HI     31
`define DAX_HIGH_LO    32
`define DAX_HIGH_HI    39
`define DAX_HIGH_SIGN  7
`endif

// ### logic/dax_pkg.sv
// Types shared by the extended ALU and MAC datapath block
package dax_pkg;
    typedef enum logic [2:0] {
        DAX_ALU_XSRC0, DAX_ALU_XSRC1, DAX_ALU_RES, DAX_ALU_MLOW,
        DAX_ALU_MMID, DAX_ALU_MHIGH, DAX_ALU_SHLO, DAX_ALU_SHHI
    } dax_xsel_t;
    typedef enum logic [2:0] {
        DAX_SQ_RES, DAX_SQ_MLOW, DAX_SQ_MMID, DAX_SQ_MHIGH,
        DAX_SQ_MX0, DAX_SQ_MX1, DAX_SQ_SHLO, DAX_SQ_SHHI
    } dax_sqsel_t;
    typedef enum logic [3:0] {
        DAX_OP_NOP, DAX_OP_PASS, DAX_OP_ADD, DAX_OP_SUB, DAX_OP_AND,
        DAX_OP_OR, DAX_OP_XOR, DAX_OP_BTST, DAX_OP_BSET, DAX_OP_BCLR,
        DAX_OP_BTGL, DAX_OP_DIVIDE_SIGN_STEP, DAX_OP_DIVIDE_QUOTIENT_STEP, DAX_OP_MOVE
    } dax_op_t;
    typedef enum logic [1:0] {
        DAX_MAC_NONE, DAX_MAC_SQ, DAX_MAC_SQ_ADD, DAX_MAC_SQ_SUB
    } dax_mac_t;
    typedef enum logic [1:0] {
        DAX_IRQ_ON, DAX_IRQ_OFF
    } dax_irq_state_t;
endpackage : dax_pkg

// ### logic/dax_bit_unit.sv
// Single-bit mask builder and operator for test, set, clear and toggle
`timescale 1ns/1ps
`include "dax_params.svh"
module dax_bit_unit
    import dax_pkg::*;
(
    input  wire logic [15:0] src,
    input  wire logic [3:0]  bit_idx,
    input  wire dax_op_t     op,
    output logic      [15:0] res
);
    logic [15:0] mask;

    always_comb begin
        mask = `DAX_ZERO;
        mask[bit_idx] = 1'b1; // [RULE5]
    end

    always_comb begin
        case (op)
            DAX_OP_BTST: res = src & mask;  // [RULE6]
            DAX_OP_BSET: res = src | mask;  // [RULE6]
            DAX_OP_BCLR: res = src & ~mask; // [RULE6]
            DAX_OP_BTGL: res = src ^ mask;  // [RULE6]
            default:     res = src;
        endcase
    end
endmodule : dax_bit_unit

// ### logic/dax_core.sv
// Extended ALU, squaring MAC, rounding mode and global interrupt gate
//
// Contract
// RULE1: Conditional pass copies operand or constant when true; no-op when false.
// RULE2: Pass writes result and flags; plain move leaves flags untouched.
// RULE3: Passing zero clears the result register, also in multifunction cycles.
// RULE4: Flags are defined only after passing constants zero, one or minus one.
// RULE5: Bit index 0..15 selects a bit, 0 being the LSB; result to either.
// RULE6: Test ANDs, set ORs, clear ANDs inverse, toggle XORs with one-hot mask.
// RULE7: Bit operations take sources from eight permitted registers only.
// RULE8: Result-free operation updates flags, leaves result and feedback unchanged.
// RULE9: Result-free form only for unconditional base ops, no divide, no constants.
// RULE10: One X register feeds both multiplier inputs for square and sum of squares.
// RULE11: Square source is one of eight permitted registers, named twice.
// RULE12: Rounding mode bit: 0 selects unbiased, 1 selects biased rounding.
// RULE13: Low word 0x8000 always rounds up if biased, only odd mid if unbiased.
// RULE14: Rounding mode sits in bit twelve of serial port autobuffer control.
// RULE15: Reset enables global servicing; enable instruction restores unmasked servicing.
// RULE16: Global disable blocks all servicing, mask register contents unchanged.
// RULE17: Global disable also blocks the powerdown interrupt.
// RULE18: Autobuffer transfers continue regardless of global interrupt state.
// RULE19: Rounding adds 0x8000 to 40-bit result; unbiased tie clears mid LSB.
`timescale 1ns/1ps
`include "dax_params.svh"
module dax_core
    import dax_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rstn,
    input  wire logic        instr_valid,
    input  wire dax_op_t     alu_op,
    input  wire logic        cond_given,
    input  wire logic        cond_true,
    input  wire logic        dest_feedback,
    input  wire logic        result_free,
    input  wire logic        use_const,
    input  wire logic [15:0] const_val,
    input  wire dax_xsel_t   xsel,
    input  wire logic [15:0] yop,
    input  wire logic [3:0]  bit_idx,
    input  wire logic [15:0] xsrc0,
    input  wire logic [15:0] xsrc1,
    input  wire logic [15:0] shift_lo,
    input  wire logic [15:0] shift_hi,
    input  wire logic [15:0] mac_x0,
    input  wire logic [15:0] mac_x1,
    input  wire dax_mac_t    mac_op,
    input  wire dax_sqsel_t  sq_xsel,
    input  wire dax_sqsel_t  sq_ysel,
    input  wire logic        mac_signed,
    input  wire logic        round_option,
    input  wire logic        abuf_ctl_we,
    input  wire logic [15:0] abuf_ctl_wdata,
    input  wire logic        global_irq_on,
    input  wire logic        global_irq_off,
    input  wire logic [15:0] irq_pending,
    input  wire logic [15:0] irq_mask_reg,
    input  wire logic        abuf_req,
    output logic      [15:0] alu_result_reg,
    output logic      [15:0] alu_feedback_reg,
    output logic      [15:0] mac_result_low,
    output logic      [15:0] mac_result_mid,
    output logic      [7:0]  mac_result_high,
    output logic      [3:0]  arith_status_reg,
    output logic             flags_defined,
    output logic             round_bias_select,
    output logic      [15:0] abuf_ctl_reg,
    output logic             irq_global_en,
    output logic      [15:0] irq_service,
    output logic             abuf_grant,
    output logic             illegal_op
);
    ////////////////////////////////////////////////////////////////////////
    // Operand selection
    logic [15:0] x_val;
    logic [15:0] y_val;
    logic [15:0] sq_val;
    logic [15:0] bit_res;
    logic [16:0] next_sum;
    logic [15:0] next_alu;
    logic        is_bit;
    logic        is_div;
    logic        exec;
    logic        rf_legal;
    logic        sq_legal;
    logic        next_flags_ok;
    dax_irq_state_t irq_state;

    // Decoded twice: ALU X operand (high MAC word) and the square operand from sq_xsel; sq_ysel is only compared
    function automatic logic [15:0] sq_pick(input dax_sqsel_t s);
        case (s)
            DAX_SQ_RES:   sq_pick = alu_result_reg;
            DAX_SQ_MLOW:  sq_pick = mac_result_low;
            DAX_SQ_MMID:  sq_pick = mac_result_mid;
            DAX_SQ_MHIGH: sq_pick = {{8{mac_result_high[`DAX_HIGH_SIGN]}}, mac_result_high};
            DAX_SQ_MX0:   sq_pick = mac_x0;
            DAX_SQ_MX1:   sq_pick = mac_x1;
            DAX_SQ_SHLO:  sq_pick = shift_lo;
            DAX_SQ_SHHI:  sq_pick = shift_hi;
            default:      sq_pick = `DAX_ZERO;
        endcase
    endfunction : sq_pick

    always_comb begin
        case (xsel) // [RULE7]
            DAX_ALU_XSRC0: x_val = xsrc0;
            DAX_ALU_XSRC1: x_val = xsrc1;
            DAX_ALU_RES:   x_val = alu_result_reg;
            DAX_ALU_MLOW:  x_val = mac_result_low;
            DAX_ALU_MMID:  x_val = mac_result_mid;
            DAX_ALU_MHIGH: x_val = sq_pick(DAX_SQ_MHIGH);
            DAX_ALU_SHLO:  x_val = shift_lo;
            DAX_ALU_SHHI:  x_val = shift_hi;
            default:       x_val = `DAX_ZERO;
        endcase
    end

    assign y_val  = use_const ? const_val : yop;
    assign sq_val = sq_pick(sq_xsel); // [RULE10]

    dax_bit_unit u_bit (
        .src     (x_val),
        .bit_idx (bit_idx),
        .op      (alu_op),
        .res     (bit_res)
    );

    ////////////////////////////////////////////////////////////////////////
    // ALU computation
    assign is_bit = (alu_op == DAX_OP_BTST) || (alu_op == DAX_OP_BSET) ||
                    (alu_op == DAX_OP_BCLR) || (alu_op == DAX_OP_BTGL);
    assign is_div = (alu_op == DAX_OP_DIVIDE_SIGN_STEP) || (alu_op == DAX_OP_DIVIDE_QUOTIENT_STEP);
    // Bit ops use constant masks, so they count as extended forms too
    assign rf_legal = !cond_given && !use_const && !is_div && !is_bit; // [RULE9]
    // Condition skipped when absent
    assign exec = instr_valid && (!cond_given || cond_true); // [RULE1]

    always_comb begin
        next_sum = {1'b0, `DAX_ZERO};
        case (alu_op)
            DAX_OP_PASS: next_alu = y_val; // [RULE1]
            DAX_OP_ADD: begin
                next_sum = {1'b0, x_val} + {1'b0, y_val};
                next_alu = next_sum[15:0];
            end
            DAX_OP_SUB: begin
                next_sum = {1'b0, x_val} - {1'b0, y_val};
                next_alu = next_sum[15:0];
            end
            DAX_OP_AND: next_alu = x_val & y_val;
            DAX_OP_OR:  next_alu = x_val | y_val;
            DAX_OP_XOR: next_alu = x_val ^ y_val;
            default:    next_alu = is_bit ? bit_res : x_val;
        endcase
    end

    // Pass of other constants leaves flags formally undefined
    assign next_flags_ok = !(alu_op == DAX_OP_PASS && use_const &&
                             const_val != `DAX_ZERO && const_val != `DAX_ONE &&
                             const_val != `DAX_MINUS_ONE); // [RULE4]

    ////////////////////////////////////////////////////////////////////////
    // ALU destination registers
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            alu_result_reg   <= `DAX_ZERO;
            alu_feedback_reg <= `DAX_ZERO;
        end else if (exec && !result_free && alu_op != DAX_OP_NOP &&
                     alu_op != DAX_OP_MOVE && !is_div) begin
            if (dest_feedback) begin
                alu_feedback_reg <= next_alu; // [RULE5]
            end else begin
                alu_result_reg <= next_alu; // [RULE2] [RULE3]
            end
        end
    end

    // Flags: zero, negative, carry, overflow; moves never touch them
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            arith_status_reg <= 4'h0;
            flags_defined    <= 1'b1;
        end else if (exec && alu_op != DAX_OP_NOP && alu_op != DAX_OP_MOVE && !is_div &&
                     (!result_free || rf_legal)) begin // [RULE2] [RULE8]
            arith_status_reg <= {next_alu == `DAX_ZERO, next_alu[15], next_sum[16],
                                 (alu_op == DAX_OP_ADD) &&
                                 (x_val[15] == y_val[15]) && (next_alu[15] != x_val[15])};
            flags_defined    <= next_flags_ok;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            illegal_op <= 1'b0;
        end else begin
            illegal_op <= instr_valid && ((result_free && !rf_legal) ||
                          (mac_op != DAX_MAC_NONE && sq_xsel != sq_ysel)); // [RULE9] [RULE11]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Squaring MAC with rounding
    logic [31:0] sq_prod;
    logic [39:0] mr_now;
    logic [39:0] mr_acc;
    logic [39:0] mr_rnd;
    logic        mac_exec;

    assign sq_legal = (sq_xsel == sq_ysel); // [RULE11]
    assign mac_exec = instr_valid && (!cond_given || cond_true) &&
                      mac_op != DAX_MAC_NONE && sq_legal;
    assign mr_now   = {mac_result_high, mac_result_mid, mac_result_low};

    always_comb begin
        // Same register feeds both multiplier ports
        if (mac_signed) begin
            sq_prod = 32'($signed(sq_val) * $signed(sq_val)); // [RULE10]
        end else begin
            sq_prod = sq_val * sq_val; // [RULE10]
        end
        case (mac_op)
            DAX_MAC_SQ_ADD: mr_acc = mr_now + {8'h00, sq_prod};
            DAX_MAC_SQ_SUB: mr_acc = mr_now - {8'h00, sq_prod};
            default:        mr_acc = {8'h00, sq_prod};
        endcase
        mr_rnd = mr_acc;
        if (round_option) begin
            mr_rnd = mr_acc + {24'h00_0000, `DAX_RND_HALF}; // [RULE19]
            // Tie: biased keeps the carry, unbiased forces mid even
            if (mr_acc[`DAX_LOW_HI:0] == `DAX_RND_HALF && !round_bias_select) begin
                mr_rnd[`DAX_MID_LO] = 1'b0; // [RULE12] [RULE13] [RULE19]
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            mac_result_low  <= `DAX_ZERO;
            mac_result_mid  <= `DAX_ZERO;
            mac_result_high <= 8'h00;
        end else if (mac_exec) begin
            mac_result_low  <= mr_rnd[`DAX_LOW_HI:0];
            mac_result_mid  <= mr_rnd[`DAX_MID_HI:`DAX_MID_LO];
            mac_result_high <= mr_rnd[`DAX_HIGH_HI:`DAX_HIGH_LO];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Autobuffer control register holding the rounding mode
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            abuf_ctl_reg <= `DAX_ZERO;
        end else if (abuf_ctl_we) begin
            abuf_ctl_reg <= abuf_ctl_wdata;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            round_bias_select <= 1'b0;
        end else if (abuf_ctl_we) begin
            round_bias_select <= abuf_ctl_wdata[`DAX_BIAS_BIT]; // [RULE14]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Global interrupt gate
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            irq_state <= DAX_IRQ_ON; // [RULE15]
        end else begin
            case (irq_state)
                DAX_IRQ_ON:  if (instr_valid && global_irq_off) irq_state <= DAX_IRQ_OFF;
                DAX_IRQ_OFF: if (instr_valid && global_irq_on) irq_state <= DAX_IRQ_ON;
                default:     irq_state <= DAX_IRQ_ON;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            irq_global_en <= 1'b1;
            irq_service   <= `DAX_ZERO;
        end else begin
            irq_global_en <= irq_state == DAX_IRQ_ON;
            // Mask register is only read here, never altered; powerdown is one of the lines
            irq_service   <= (irq_state == DAX_IRQ_ON) ? (irq_pending & irq_mask_reg)
                             : `DAX_ZERO; // [RULE15] [RULE16] [RULE17]
        end
    end

    // Autobuffer path ignores the global gate on purpose
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            abuf_grant <= 1'b0;
        end else begin
            abuf_grant <= abuf_req; // [RULE18]
        end
    end
endmodule : dax_core

// ### verif/dax_core_checker.sv
// Concurrent checks on the extended ALU and MAC datapath ports
`timescale 1ns/1ps
module dax_core_checker
    import dax_pkg::*;
(
    input wire logic        clk_sys,
    input wire logic        rstn,
    input wire logic        instr_valid,
    input wire dax_op_t     alu_op,
    input wire logic        cond_given,
    input wire logic        cond_true,
    input wire logic        result_free,
    input wire logic        use_const,
    input wire dax_mac_t    mac_op,
    input wire dax_sqsel_t  sq_xsel,
    input wire dax_sqsel_t  sq_ysel,
    input wire logic        abuf_ctl_we,
    input wire logic [15:0] abuf_ctl_wdata,
    input wire logic        global_irq_on,
    input wire logic        global_irq_off,
    input wire logic [15:0] alu_result_reg,
    input wire logic [15:0] alu_feedback_reg,
    input wire logic [15:0] mac_result_low,
    input wire logic [3:0]  arith_status_reg,
    input wire logic        round_bias_select,
    input wire logic        irq_global_en,
    input wire logic [15:0] irq_service,
    input wire logic        illegal_op
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    // The gate outputs lag the instruction by two edges, so each check looks two ahead
    sequence s_off; instr_valid && global_irq_off; endsequence
    sequence s_on; instr_valid && global_irq_on && !global_irq_off; endsequence
    chk_cond_false_hold: assert property (instr_valid && cond_given && !cond_true
        |=> $stable(alu_result_reg) && $stable(alu_feedback_reg)) else $error("false cond wrote");
    chk_move_flags_kept: assert property (instr_valid && alu_op == DAX_OP_MOVE
        |=> $stable(arith_status_reg)) else $error("move changed flags");
    chk_free_result_kept: assert property (instr_valid && result_free
        |=> $stable(alu_result_reg) && $stable(alu_feedback_reg)) else $error("free op wrote");
    chk_free_form_refused: assert property (instr_valid && result_free && (cond_given
        || use_const || alu_op inside {DAX_OP_DIVIDE_SIGN_STEP, DAX_OP_DIVIDE_QUOTIENT_STEP}) |=> illegal_op)
        else $error("bad free form accepted");
    chk_square_same_reg: assert property (instr_valid && mac_op != DAX_MAC_NONE
        && sq_xsel != sq_ysel |=> illegal_op && $stable(mac_result_low))
        else $error("mixed square accepted");
    chk_bias_bit_twelve: assert property (abuf_ctl_we
        |=> round_bias_select == $past(abuf_ctl_wdata[12])) else $error("bias bit wrong");
    chk_global_off_blocks: assert property (s_off |-> ##2
        (!irq_global_en && irq_service == 16'h0000)) else $error("service not blocked");
    chk_global_on_opens: assert property (s_on |-> ##2 irq_global_en)
        else $error("service not enabled");
endmodule : dax_core_checker
////////////////////////////////////////////////////////////////////////////////
bind dax_core dax_core_checker u_chk (.clk_sys, .rstn, .instr_valid, .alu_op, .cond_given,
    .cond_true, .result_free, .use_const, .mac_op, .sq_xsel, .sq_ysel, .abuf_ctl_we,
    .abuf_ctl_wdata, .global_irq_on, .global_irq_off, .alu_result_reg, .alu_feedback_reg,
    .mac_result_low, .arith_status_reg, .round_bias_select, .irq_global_en, .irq_service,
    .illegal_op);

// ### verif/dax_regfile_model.sv
// Register file model that feeds the datapath's source operands
`timescale 1ns/1ps
module dax_regfile_model (
    input  wire logic        clk_sys,
    input  wire logic        wr_en,
    input  wire logic [2:0]  wr_sel,
    input  wire logic [15:0] wr_data,
    output logic      [15:0] xsrc0,
    output logic      [15:0] xsrc1,
    output logic      [15:0] shift_lo,
    output logic      [15:0] shift_hi,
    output logic      [15:0] mac_x0,
    output logic      [15:0] mac_x1
);
    // No reset: unwritten entries stay unknown so a stray read shows in compares
    logic [15:0] mem [6];
    always_ff @(posedge clk_sys) begin
        if (wr_en && wr_sel < 3'h6) begin
            mem[wr_sel] <= wr_data;
        end
    end
    assign {xsrc0, xsrc1, shift_lo} = {mem[0], mem[1], mem[2]};
    assign {shift_hi, mac_x0, mac_x1} = {mem[3], mem[4], mem[5]};
endmodule : dax_regfile_model

// ### verif/dax_core_test.sv
// Self-checking bench for the extended ALU and MAC datapath
`timescale 1ns/1ps
module dax_core_test
    import dax_pkg::*;
;
    logic clk_sys = 1'b0, rstn = 1'b0, instr_valid = 1'b0, cond_given = 1'b0, cond_true = 1'b0;
    logic dest_feedback = 1'b0, result_free = 1'b0, use_const = 1'b0, mac_signed = 1'b0;
    logic round_option = 1'b0, abuf_ctl_we = 1'b0, abuf_req = 1'b0, wr_en = 1'b0, ill;
    logic global_irq_on = 1'b0, global_irq_off = 1'b0;
    logic [15:0] const_val = 16'h0000, yop = 16'h0000, abuf_ctl_wdata = 16'h0000;
    // Bit 0 of the pending word stands for the powerdown request
    logic [15:0] irq_pending = 16'h00F3, irq_mask_reg = 16'h0F0F, wr_data = 16'h0000, r, f, e;
    logic [3:0]  bit_idx = 4'h0;
    logic [2:0]  wr_sel = 3'h0;
    dax_op_t     alu_op = DAX_OP_NOP;
    dax_xsel_t   xsel = DAX_ALU_XSRC0;
    dax_mac_t    mac_op = DAX_MAC_NONE;
    dax_sqsel_t  sq_xsel = DAX_SQ_MX0, sq_ysel = DAX_SQ_MX0;
    logic [15:0] v [6] = '{16'hA5C3, 16'h0001, 16'h00FF, 16'hF00F, 16'h0080, 16'h0100};
    dax_xsel_t   sel [4] = '{DAX_ALU_XSRC0, DAX_ALU_XSRC1, DAX_ALU_SHLO, DAX_ALU_SHHI};
    dax_op_t     ops [4] = '{DAX_OP_BTST, DAX_OP_BSET, DAX_OP_BCLR, DAX_OP_BTGL};
    wire [15:0]  xsrc0, xsrc1, shift_lo, shift_hi, mac_x0, mac_x1, alu_result_reg, irq_service;
    wire [15:0]  alu_feedback_reg, mac_result_low, mac_result_mid, abuf_ctl_reg;
    wire [7:0]   mac_result_high;
    wire [3:0]   arith_status_reg;
    wire         flags_defined, round_bias_select, irq_global_en, abuf_grant, illegal_op;
    int          bad_count = 0, n_checks = 0;
    always #5 clk_sys = ~clk_sys;
    dax_regfile_model u_rf (.clk_sys, .wr_en, .wr_sel, .wr_data, .xsrc0, .xsrc1, .shift_lo,
        .shift_hi, .mac_x0, .mac_x1);
    dax_core uut (.clk_sys, .rstn, .instr_valid, .alu_op, .cond_given, .cond_true,
        .dest_feedback, .result_free, .use_const, .const_val, .xsel, .yop, .bit_idx, .xsrc0,
        .xsrc1, .shift_lo, .shift_hi, .mac_x0, .mac_x1, .mac_op, .sq_xsel, .sq_ysel, .mac_signed,
        .round_option, .abuf_ctl_we, .abuf_ctl_wdata, .global_irq_on, .global_irq_off,
        .irq_pending, .irq_mask_reg, .abuf_req, .alu_result_reg, .alu_feedback_reg,
        .mac_result_low, .mac_result_mid, .mac_result_high, .arith_status_reg, .flags_defined,
        .round_bias_select, .abuf_ctl_reg, .irq_global_en, .irq_service, .abuf_grant,
        .illegal_op);
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [47:0] seen, input logic [47:0] exp, input string what);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : chk
    task automatic tick();
        @(posedge clk_sys);
        #1;
    endtask : tick
    // One idle cycle after each instruction keeps the valid strobe from retriggering
    task automatic alu(input dax_op_t op, input logic cg, ct, fb, rf, uc, input logic [15:0] cv);
        alu_op = op;
        cond_given = cg;
        cond_true = ct;
        dest_feedback = fb;
        result_free = rf;
        use_const = uc;
        const_val = cv;
        instr_valid = 1'b1;
        tick();
        ill = illegal_op;
        instr_valid = 1'b0;
        tick();
    endtask : alu
    task automatic mac(input dax_mac_t op, input dax_sqsel_t xs, ys, input logic rnd);
        mac_op = op;
        sq_xsel = xs;
        sq_ysel = ys;
        round_option = rnd;
        alu(DAX_OP_NOP, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 16'h0000);
    endtask : mac
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : close_out
    initial begin
        repeat (20000) @(posedge clk_sys);
        bad_count++;
        close_out();
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        // Every input change lands just after a rising edge, the first one included
        tick();
        for (int i = 0; i < 6; i++) begin
            wr_sel = 3'(i);
            wr_data = v[i];
            wr_en = 1'b1;
            tick();
            wr_en = 1'b0;
            tick();
        end
        repeat (7) tick();
        rstn = 1'b1;
        repeat (2) tick();
        chk({alu_result_reg, irq_global_en, flags_defined, irq_service}, 35'h3_0003, "reset");
        yop = 16'h1234;
        alu(DAX_OP_PASS, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 16'h0000);
        chk(alu_result_reg, 16'h1234, "pass reg");
        alu(DAX_OP_PASS, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 16'h0000);
        chk(alu_result_reg, 16'h1234, "false cond");
        alu(DAX_OP_PASS, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 16'hFFFF);
        chk({alu_feedback_reg, alu_result_reg}, 32'hFFFF_1234, "true cond");
        chk({flags_defined, arith_status_reg[3:2]}, 3'b101, "minus one flags");
        alu(DAX_OP_MOVE, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 16'h0000);
        chk(arith_status_reg[3:2], 2'b01, "move flags");
        alu(DAX_OP_PASS, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 16'h0000);
        chk({alu_result_reg, flags_defined, arith_status_reg[3:2]}, 19'h0_0006, "zero");
        alu(DAX_OP_PASS, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 16'h0001);
        chk({alu_result_reg, flags_defined, arith_status_reg[3:2]}, 19'h0_000C, "one");
        alu(DAX_OP_PASS, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 16'h0005);
        chk({alu_result_reg, flags_defined}, 17'h0_000A, "other const");
        for (int k = 0; k < 64; k++) begin
            xsel = sel[(k / 4) % 4];
            bit_idx = 4'(k / 4);
            f = v[(k / 4) % 4];
            r = 16'h0001 << (k / 4);
            e = (k % 4 == 0) ? f & r : (k % 4 == 1) ? f | r : (k % 4 == 2) ? f & ~r : f ^ r;
            alu(ops[k % 4], 1'b0, 1'b0, k[4], 1'b0, 1'b0, 16'h0000);
            chk(k[4] ? alu_feedback_reg : alu_result_reg, e, "bit op");
        end
        xsel = DAX_ALU_XSRC1;
        yop = 16'hFFFF;
        r = alu_result_reg;
        f = alu_feedback_reg;
        alu(DAX_OP_ADD, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 16'h0000);
        chk({alu_result_reg, alu_feedback_reg, arith_status_reg, ill}, {r, f, 4'b1010, 1'b0},
            "free");
        for (int j = 0; j < 3; j++) begin
            alu(j == 2 ? DAX_OP_DIVIDE_SIGN_STEP : DAX_OP_ADD, j == 1, 1'b1, 1'b0, 1'b1, j == 0, 16'h0001);
            // Refused forms leave the flags of the last legal free operation in place
            chk({alu_result_reg, alu_feedback_reg, arith_status_reg, ill}, {r, f, 4'b1010, 1'b1},
                "free refused");
        end
        mac(DAX_MAC_SQ, DAX_SQ_MX0, DAX_SQ_MX0, 1'b0);
        chk(mac_result_low, 16'h4000, "square");
        mac(DAX_MAC_SQ_ADD, DAX_SQ_MX0, DAX_SQ_MX0, 1'b0);
        chk(mac_result_low, 16'h8000, "sum squares");
        mac(DAX_MAC_SQ_SUB, DAX_SQ_MX0, DAX_SQ_MX0, 1'b0);
        chk(mac_result_low, 16'h4000, "sub square");
        mac(DAX_MAC_SQ, DAX_SQ_MX1, DAX_SQ_MX1, 1'b0);
        mac(DAX_MAC_SQ, DAX_SQ_MX0, DAX_SQ_MX1, 1'b0);
        chk({mac_result_high, mac_result_mid, mac_result_low, ill}, 41'h000_0002_0001, "mixed");
        mac_signed = 1'b1;
        mac(DAX_MAC_SQ, DAX_SQ_SHHI, DAX_SQ_SHHI, 1'b0);
        mac_signed = 1'b0;
        chk({mac_result_high, mac_result_mid, mac_result_low}, 40'h00_00FE_20E1,
            "signed sq");
        mac_op = DAX_MAC_NONE;
        xsel = DAX_ALU_MLOW;
        bit_idx = 4'h5;
        alu(DAX_OP_BTST, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 16'h0000);
        chk(alu_result_reg, 16'h0020, "bit from mac");
        for (int b = 0; b < 2; b++) begin
            abuf_ctl_wdata = b ? 16'h1000 : 16'h0000;
            abuf_ctl_we = 1'b1;
            tick();
            abuf_ctl_we = 1'b0;
            chk({round_bias_select, abuf_ctl_reg}, {b[0], abuf_ctl_wdata}, "bias");
            mac(DAX_MAC_SQ, DAX_SQ_MX0, DAX_SQ_MX0, 1'b0);
            mac(DAX_MAC_SQ_ADD, DAX_SQ_MX0, DAX_SQ_MX0, 1'b1);
            chk(mac_result_mid, 16'(b), "tie even");
            mac(DAX_MAC_SQ, DAX_SQ_MX1, DAX_SQ_MX1, 1'b0);
            mac(DAX_MAC_SQ_ADD, DAX_SQ_MX0, DAX_SQ_MX0, 1'b0);
            mac(DAX_MAC_SQ_ADD, DAX_SQ_MX0, DAX_SQ_MX0, 1'b1);
            chk(mac_result_mid, 16'h0002, "tie odd");
        end
        mac_op = DAX_MAC_NONE;
        abuf_req = 1'b1;
        global_irq_off = 1'b1;
        alu(DAX_OP_NOP, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 16'h0000);
        global_irq_off = 1'b0;
        chk({irq_global_en, irq_service, abuf_grant}, 18'h0_0001, "off");
        global_irq_on = 1'b1;
        alu(DAX_OP_NOP, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 16'h0000);
        global_irq_on = 1'b0;
        chk({irq_global_en, irq_service, abuf_grant}, 18'h2_0007, "on");
        close_out();
    end
endmodule : dax_core_test
